// *** dte_engine.sv ***
// descriptor transfer engine with apb control and bus master
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "dte_defines.svh"
module dte_engine
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // activation
    input  wire logic        act_req,
    input  wire logic [7:0]  act_vector,
    output logic             act_accept,
    output logic             busy,
    // system bus master
    output logic             bus_req,
    output logic             bus_we,
    output logic      [31:0] bus_addr,
    output logic      [1:0]  bus_size,
    output logic      [31:0] bus_wdata,
    input  wire logic        bus_ack,
    input  wire logic [31:0] bus_rdata,
    // cpu interrupt
    output logic             cpu_irq,
    output logic      [7:0]  cpu_irq_vector
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    dte_pkg::dte_state_e state_q;
    logic [1:0]  ctrl_q;
    logic [31:0] vbase_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] source_address_reg_q;
    logic [31:0] destination_address_reg_q;
    logic [15:0] count_reg_a_q;
    logic [15:0] count_reg_b_q;
    logic [7:0]  mode_reg_a_q;
    logic [7:0]  mode_reg_b_q;
    logic [31:0] desc_addr_q;
    logic [1:0]  desc_idx_q;
    logic [1:0]  wb_idx_q;
    logic [31:0] dat_q;
    logic [2:0]  rem_q;
    logic [8:0]  blk_left_q;
    logic [7:0]  vec_q;
    logic [7:0]  last_vec_q;
    logic        vec_valid_q;
    logic        last_chain_q;
    logic        chained_q;
    logic        zero_q;
    logic        fmt_short_q;
    logic        busy_q;
    logic        act_accept_q;
    logic        cpu_irq_q;
    logic [7:0]  irq_vec_q;
    logic        bus_req_q;
    logic        bus_we_q;
    logic [31:0] bus_addr_q;
    logic [1:0]  bus_size_q;
    logic [31:0] bus_wdata_q;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire        apb_acc   = psel & penable;
    wire        hit_ctrl  = (paddr == `DTE_OFF_CTRL);
    wire        hit_vbase = (paddr == `DTE_OFF_VBASE);
    wire        hit_stat  = (paddr == `DTE_OFF_STATUS);
    wire        apb_hit   = hit_ctrl | hit_vbase | hit_stat;
    wire        apb_wr    = apb_acc & pready_q & pwrite;
    wire        ctrl_wr   = apb_wr & hit_ctrl;
    wire        rrs_clear = ctrl_wr & ~pwdata[`DTE_CTRL_RRS];
    wire [1:0]  ctrl_d    = ctrl_wr ? pwdata[1:0] : ctrl_q;
    wire [31:0] status_w  = {16'h0000, last_vec_q, 5'h00, last_chain_q, vec_valid_q, busy_q};
    wire [31:0] apb_rd    = hit_ctrl  ? {30'h0000_0000, ctrl_q} :
                            hit_vbase ? vbase_q :
                            hit_stat  ? status_w : 32'h0000_0000;

    // ----------------------------------------
    // descriptor fields
    // ----------------------------------------
    wire [1:0]  mode   = mode_reg_a_q[`DTE_MRA_MD];
    wire [1:0]  sz     = mode_reg_a_q[`DTE_MRA_SZ];
    wire        sm1    = mode_reg_a_q[`DTE_MRA_SM1];
    wire        sm0    = mode_reg_a_q[`DTE_MRA_SM0];
    wire        dm1    = mode_reg_b_q[`DTE_MRB_DM1];
    wire        dm0    = mode_reg_b_q[`DTE_MRB_DM0];
    wire        chain_enable   = mode_reg_b_q[`DTE_MRB_CHAIN_ENABLE];
    wire        chain_on_zero_select   = mode_reg_b_q[`DTE_MRB_CHAIN_ON_ZERO_SELECT];
    wire        per_transfer_irq_select  = mode_reg_b_q[`DTE_MRB_PER_TRANSFER_IRQ_SELECT];
    wire        dts    = mode_reg_b_q[`DTE_MRB_DTS];
    wire        is_rep = (mode == `DTE_MD_REPEAT);
    wire        is_blk = (mode == `DTE_MD_BLOCK);
    wire [7:0]  count_a_reload_byte = count_reg_a_q[15:8];
    wire [7:0]  count_a_low_counter = count_reg_a_q[7:0];
    wire [8:0]  count_a_reload_byte_n = {count_a_reload_byte == 8'h00, count_a_reload_byte};
    wire [2:0]  len    = fmt_short_q ? `DTE_LEN_SHORT : `DTE_LEN_FULL;
    wire [2:0]  unit_b = (sz == `DTE_SZ_BYTE) ? 3'h1 : (sz == `DTE_SZ_WORD) ? 3'h2 : 3'h4;
    wire [31:0] unit32 = {29'h0000_0000, unit_b};
    wire [31:0] span   = {23'h00_0000, count_a_reload_byte_n} << sz;
    wire        skip_hit = ctrl_q[`DTE_CTRL_RRS] & vec_valid_q
                           & (act_vector == last_vec_q) & ~last_chain_q & ~rrs_clear;

    // ----------------------------------------
    // address stepping and repeat/block restore
    // ----------------------------------------
    wire [31:0] sar_step = sm1 ? (sm0 ? source_address_reg_q - unit32
                                      : source_address_reg_q + unit32)
                               : source_address_reg_q;
    wire [31:0] dar_step = dm1 ? (dm0 ? destination_address_reg_q - unit32
                                      : destination_address_reg_q + unit32)
                               : destination_address_reg_q;
    wire [31:0] sar_rst  = sm1 ? (sm0 ? sar_step + span : sar_step - span) : sar_step;
    wire [31:0] dar_rst  = dm1 ? (dm0 ? dar_step + span : dar_step - span) : dar_step;
    wire        rep_last = (count_a_low_counter == 8'h01);
    wire        blk_more = (blk_left_q > 9'h001);
    wire        restore  = is_blk | (is_rep & rep_last);
    wire        zero_d   = is_blk ? (count_reg_b_q == 16'h0001) :
                           is_rep ? rep_last : (count_reg_a_q == 16'h0001);
    wire [15:0] cra_upd  = is_blk ? {count_a_reload_byte, count_a_reload_byte} :
                           is_rep ? (rep_last ? {count_a_reload_byte, count_a_reload_byte}
                                     : {count_a_reload_byte, count_a_low_counter - 8'h01})
                                  : count_reg_a_q - 16'h0001;

    // ----------------------------------------
    // data piece split and packing
    // ----------------------------------------
    wire [31:0] dat_off  = {29'h0000_0000, unit_b - rem_q};
    wire [31:0] dat_base = (state_q == dte_pkg::ST_RD) ? source_address_reg_q
                                                        : destination_address_reg_q;
    wire [31:0] dat_addr = dat_base + dat_off;
    wire [2:0]  piece    = (rem_q == 3'h4 && dat_addr[1:0] == 2'h0) ? 3'h4 :
                           (rem_q >= 3'h2 && !dat_addr[0]) ? 3'h2 : 3'h1;
    wire [1:0]  piece_sz = (piece == 3'h4) ? `DTE_SZ_LONG :
                           (piece == 3'h2) ? `DTE_SZ_WORD : `DTE_SZ_BYTE;
    wire [31:0] rd_acc   = (piece == 3'h1) ? {dat_q[23:0], bus_rdata[7:0]} :
                           (piece == 3'h2) ? {dat_q[15:0], bus_rdata[15:0]} : bus_rdata;
    wire [2:0]  wr_left  = rem_q - piece;
    wire [31:0] wr_shift = dat_q >> {wr_left, 3'b000};
    wire [31:0] wr_data  = (piece == 3'h1) ? {24'h00_0000, wr_shift[7:0]} :
                           (piece == 3'h2) ? {16'h0000, wr_shift[15:0]} : wr_shift;

    // ----------------------------------------
    // writeback selection
    // ----------------------------------------
    wire        wb_last  = ({1'b0, wb_idx_q} == len - 3'h1);
    wire        wb_cnt   = wb_last;
    wire        wb_src   = fmt_short_q ? (wb_idx_q == 2'h0) : (wb_idx_q == 2'h1);
    wire        wb_dst   = fmt_short_q ? (wb_idx_q == 2'h1) : (wb_idx_q == 2'h2);
    wire        wb_need  = wb_cnt | (wb_src & sm1) | (wb_dst & dm1);
    wire [31:0] wb_data  = wb_cnt ? {count_reg_a_q, count_reg_b_q} :
                           wb_src ? (fmt_short_q ? {mode_reg_a_q, source_address_reg_q[23:0]}
                                                 : source_address_reg_q) :
                           (fmt_short_q ? {mode_reg_b_q, destination_address_reg_q[23:0]}
                                        : destination_address_reg_q);
    wire        chain_go = chain_enable & (~chain_on_zero_select | zero_q);

    // ----------------------------------------
    // bus request selection
    // ----------------------------------------
    wire        st_vec   = (state_q == dte_pkg::ST_VEC);
    wire        st_desc  = (state_q == dte_pkg::ST_DESC);
    wire        st_rd    = (state_q == dte_pkg::ST_RD);
    wire        st_wr    = (state_q == dte_pkg::ST_WR);
    wire        st_wb    = (state_q == dte_pkg::ST_WB);
    wire        wants    = st_vec | st_desc | st_rd | st_wr | (st_wb & wb_need);
    wire        issue    = wants & ~bus_req_q;
    wire        bus_done = bus_req_q & bus_ack;
    wire [31:0] iss_addr = st_vec  ? vbase_q + {22'h00_0000, vec_q, 2'b00} :
                           st_desc ? desc_addr_q + {28'h000_0000, desc_idx_q, 2'b00} :
                           st_wb   ? desc_addr_q + {28'h000_0000, wb_idx_q, 2'b00} :
                                     dat_addr;
    wire [1:0]  iss_size = (st_rd | st_wr) ? piece_sz : `DTE_SZ_LONG;
    wire [31:0] iss_data = st_wb ? wb_data : wr_data;

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            ctrl_q    <= `DTE_CTRL_RESET;
            vbase_q   <= `DTE_VBASE_RESET;
        end
        else
        begin
            pready_q  <= apb_acc & ~pready_q;
            pslverr_q <= apb_acc & ~pready_q & ~apb_hit;
            prdata_q  <= (apb_acc & ~pready_q & ~pwrite) ? apb_rd : 32'h0000_0000;
            ctrl_q    <= ctrl_d;
            if (apb_wr & hit_vbase)
                vbase_q <= pwdata;
        end
    end

    // ----------------------------------------
    // bus master request
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_req_q   <= 1'b0;
            bus_we_q    <= 1'b0;
            bus_addr_q  <= 32'h0000_0000;
            bus_size_q  <= `DTE_SZ_BYTE;
            bus_wdata_q <= 32'h0000_0000;
        end
        else if (issue)
        begin
            bus_req_q   <= 1'b1;
            bus_we_q    <= st_wr | st_wb;
            bus_addr_q  <= iss_addr;
            bus_size_q  <= iss_size;
            bus_wdata_q <= iss_data;
        end
        else if (bus_done)
            bus_req_q <= 1'b0;
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= dte_pkg::ST_IDLE;
            {source_address_reg_q, destination_address_reg_q, desc_addr_q, dat_q} <= 128'h0;
            {count_reg_a_q, count_reg_b_q, mode_reg_a_q, mode_reg_b_q} <= 48'h0;
            {desc_idx_q, wb_idx_q, rem_q, blk_left_q} <= 16'h0000;
            {vec_q, last_vec_q, irq_vec_q} <= 24'h00_0000;
            {vec_valid_q, last_chain_q, chained_q, zero_q} <= 4'h0;
            {fmt_short_q, busy_q, act_accept_q, cpu_irq_q} <= 4'h0;
        end
        else
        begin
            act_accept_q <= 1'b0;
            cpu_irq_q    <= 1'b0;
            if (rrs_clear)
                vec_valid_q <= 1'b0;
            case (state_q)
                dte_pkg::ST_IDLE:
                    if (act_req)
                    begin
                        vec_q        <= act_vector;
                        act_accept_q <= 1'b1;
                        busy_q       <= 1'b1;
                        chained_q    <= 1'b0;
                        fmt_short_q  <= ctrl_q[`DTE_CTRL_FMT];
                        state_q      <= skip_hit ? dte_pkg::ST_PREP : dte_pkg::ST_VEC;
                    end
                dte_pkg::ST_VEC:
                    if (bus_done)
                    begin
                        desc_addr_q <= {bus_rdata[31:2], 2'b00};
                        desc_idx_q  <= 2'h0;
                        state_q     <= dte_pkg::ST_DESC;
                    end
                dte_pkg::ST_DESC:
                    if (bus_done)
                    begin
                        case (desc_idx_q)
                            2'h0:
                            begin
                                mode_reg_a_q <= bus_rdata[31:24];
                                if (fmt_short_q)
                                    source_address_reg_q <= {8'h00, bus_rdata[23:0]};
                                else
                                    mode_reg_b_q <= bus_rdata[23:16];
                            end
                            2'h1:
                                if (fmt_short_q)
                                begin
                                    mode_reg_b_q              <= bus_rdata[31:24];
                                    destination_address_reg_q <= {8'h00, bus_rdata[23:0]};
                                end
                                else
                                    source_address_reg_q <= bus_rdata;
                            2'h2:
                                if (fmt_short_q)
                                    {count_reg_a_q, count_reg_b_q} <= bus_rdata;
                                else
                                    destination_address_reg_q <= bus_rdata;
                            default:
                                {count_reg_a_q, count_reg_b_q} <= bus_rdata;
                        endcase
                        desc_idx_q <= desc_idx_q + 2'h1;
                        if ({1'b0, desc_idx_q} == len - 3'h1)
                            state_q <= dte_pkg::ST_PREP;
                    end
                dte_pkg::ST_PREP:
                begin
                    rem_q      <= unit_b;
                    blk_left_q <= is_blk ? count_a_reload_byte_n : 9'h001;
                    dat_q      <= 32'h0000_0000;
                    state_q    <= dte_pkg::ST_RD;
                end
                dte_pkg::ST_RD:
                    if (bus_done)
                    begin
                        dat_q <= rd_acc;
                        rem_q <= (rem_q == piece) ? unit_b : wr_left;
                        if (rem_q == piece)
                            state_q <= dte_pkg::ST_WR;
                    end
                dte_pkg::ST_WR:
                    if (bus_done)
                    begin
                        rem_q <= wr_left;
                        if (rem_q == piece)
                            state_q <= dte_pkg::ST_UPD;
                    end
                dte_pkg::ST_UPD:
                    if (is_blk && blk_more)
                    begin
                        source_address_reg_q      <= sar_step;
                        destination_address_reg_q <= dar_step;
                        count_reg_a_q <= {count_a_reload_byte, count_a_low_counter - 8'h01};
                        blk_left_q    <= blk_left_q - 9'h001;
                        rem_q         <= unit_b;
                        state_q       <= dte_pkg::ST_RD;
                    end
                    else
                    begin
                        source_address_reg_q      <= (restore & dts) ? sar_rst : sar_step;
                        destination_address_reg_q <= (restore & ~dts) ? dar_rst : dar_step;
                        count_reg_a_q <= cra_upd;
                        if (is_blk)
                            count_reg_b_q <= count_reg_b_q - 16'h0001;
                        zero_q   <= zero_d;
                        wb_idx_q <= 2'h0;
                        state_q  <= dte_pkg::ST_WB;
                    end
                dte_pkg::ST_WB:
                    if (!wb_need || bus_done)
                    begin
                        wb_idx_q <= wb_idx_q + 2'h1;
                        if (wb_last && chain_go)
                        begin
                            desc_addr_q <= desc_addr_q + {27'h000_0000, len, 2'b00};
                            desc_idx_q  <= 2'h0;
                            chained_q   <= 1'b1;
                            state_q     <= dte_pkg::ST_DESC;
                        end
                        else if (wb_last)
                            state_q <= dte_pkg::ST_END;
                    end
                dte_pkg::ST_END:
                begin
                    cpu_irq_q    <= per_transfer_irq_select | zero_q;
                    irq_vec_q    <= vec_q;
                    last_vec_q   <= vec_q;
                    vec_valid_q  <= ctrl_d[`DTE_CTRL_RRS];
                    last_chain_q <= chained_q;
                    busy_q       <= 1'b0;
                    state_q      <= dte_pkg::ST_IDLE;
                end
                default:
                    state_q <= dte_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign act_accept     = act_accept_q;
    assign busy           = busy_q;
    assign bus_req        = bus_req_q;
    assign bus_we         = bus_we_q;
    assign bus_addr       = bus_addr_q;
    assign bus_size       = bus_size_q;
    assign bus_wdata      = bus_wdata_q;
    assign cpu_irq        = cpu_irq_q;
    assign cpu_irq_vector = irq_vec_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_desc_align: assert property ((st_desc | st_vec) && bus_req |-> bus_addr[1:0] == 2'h0)
        else $error("descriptor access not longword aligned");
    chk_word_split: assert property (bus_req && bus_size == `DTE_SZ_WORD |-> !bus_addr[0])
        else $error("word access at odd address");
    chk_long_split: assert property (bus_req && bus_size == `DTE_SZ_LONG |-> bus_addr[1:0] == 2'h0)
        else $error("longword access not aligned");
    chk_mode_nowb: assert property (st_wb && bus_req && !fmt_short_q |-> wb_idx_q != 2'h0)
        else $error("mode registers written back");
    chk_src_skip: assert property (st_wb && bus_req && wb_src |-> sm1)
        else $error("fixed source address written back");
    chk_single_act: assert property (act_accept |-> !$past(busy_q) ##1 busy)
        else $error("activation taken while busy");
    chk_chain_cond: assert property (st_desc && $past(st_wb) |-> $past(chain_go))
        else $error("chain without its condition");
    chk_irq_cause: assert property (cpu_irq |-> ($past(per_transfer_irq_select) || $past(zero_q)) && !busy)
        else $error("interrupt without cause");
    chk_rrs_clear: assert property (rrs_clear && !(state_q == dte_pkg::ST_END) |=> !vec_valid_q)
        else $error("stored vector kept after read skip clear");
    chk_skip_path: assert property (st_vec |-> !$past(skip_hit) || $past(st_vec))
        else $error("fetch performed on skip hit");

    cov_chain: cover property (st_wb ##1 st_desc);
    cov_skip: cover property (state_q == dte_pkg::ST_IDLE && act_req && skip_hit);
    cov_bwb: cover property (st_rd && bus_done && piece == 3'h1 && sz == `DTE_SZ_LONG);
    cov_block: cover property (state_q == dte_pkg::ST_UPD && is_blk && blk_more);
endmodule

// *** dte_defines.svh ***
// constants for the descriptor transfer engine
`ifndef DTE_DEFINES_SVH
`define DTE_DEFINES_SVH
// apb register map
`define DTE_OFF_CTRL     32'h0000_0000
`define DTE_OFF_VBASE    32'h0000_0004
`define DTE_OFF_STATUS   32'h0000_0008
`define DTE_CTRL_RRS     0
`define DTE_CTRL_FMT     1
`define DTE_CTRL_RESET   2'h0
`define DTE_VBASE_RESET  32'h0000_0000
// mode_reg_a fields
`define DTE_MRA_SM1      7
`define DTE_MRA_SM0      6
`define DTE_MRA_MD       5:4
`define DTE_MRA_SZ       3:2
// mode_reg_b fields
`define DTE_MRB_CHAIN_ENABLE     7
`define DTE_MRB_CHAIN_ON_ZERO_SELECT     6
`define DTE_MRB_PER_TRANSFER_IRQ_SELECT    5
`define DTE_MRB_DTS      4
`define DTE_MRB_DM1      3
`define DTE_MRB_DM0      2
// encodings
`define DTE_MD_NORMAL    2'h0
`define DTE_MD_REPEAT    2'h1
`define DTE_MD_BLOCK     2'h2
`define DTE_SZ_BYTE      2'h0
`define DTE_SZ_WORD      2'h1
`define DTE_SZ_LONG      2'h2
`define DTE_LEN_SHORT    3'h3
`define DTE_LEN_FULL     3'h4
`endif

// *** dte_pkg.sv ***
// types for the descriptor transfer engine
package dte_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_VEC, ST_DESC, ST_PREP, ST_RD, ST_WR, ST_UPD, ST_WB, ST_END
    } dte_state_e;
endpackage

// *** dte_mem.sv ***
// system bus memory model for the transfer engine
`timescale 1ns/1ps
module dte_mem
(
    // clock
    input  wire logic        pclk,
    // system bus
    input  wire logic        bus_req,
    input  wire logic        bus_we,
    input  wire logic [31:0] bus_addr,
    input  wire logic [1:0]  bus_size,
    input  wire logic [31:0] bus_wdata,
    output logic             bus_ack,
    output logic      [31:0] bus_rdata
);
    logic [7:0]  m [0:255];
    logic [31:0] r;
    int          n, w, dly, nb;
    always @(posedge pclk)
    begin
        bus_ack   <= 1'b0;
        bus_rdata <= ~bus_rdata;
        nb = 1 << bus_size;
        if (bus_req && !bus_ack && w < dly)
            w = w + 1;
        else if (bus_req && !bus_ack)
        begin
            w = 0;
            n = n + 1;
            r = 32'h0;
            for (int i = 0; i < nb; i++)
                if (bus_we)
                    m[bus_addr[7:0] + i] = bus_wdata[8 * (nb - 1 - i) +: 8];
                else
                    r = {r[23:0], m[bus_addr[7:0] + i]};
            bus_ack   <= 1'b1;
            bus_rdata <= r;
        end
    end
endmodule

// *** test_descriptor_transfer_engine.sv ***
// testbench for the descriptor transfer engine
`timescale 1ns/1ps
module test_descriptor_transfer_engine;
    logic        pclk, presetn, psel, penable, pwrite, act_req, pready, pslverr;
    logic        act_accept, busy, bus_req, bus_we, bus_ack, cpu_irq;
    logic [31:0] paddr, pwdata, prdata, bus_addr, bus_wdata, bus_rdata;
    logic [7:0]  act_vector, cpu_irq_vector;
    logic [1:0]  bus_size;
    int          errors, comparisons, irqs, n0;
    dte_engine DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .act_req(act_req), .act_vector(act_vector),
        .act_accept(act_accept), .busy(busy), .bus_req(bus_req), .bus_we(bus_we),
        .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
        .bus_rdata(bus_rdata), .cpu_irq(cpu_irq), .cpu_irq_vector(cpu_irq_vector));
    dte_mem mem (.pclk(pclk), .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
        .bus_size(bus_size), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk)
        if (cpu_irq === 1'b1)
            irqs++;
    task chk(input logic [31:0] g, e);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task apb_wr(input logic [31:0] a, d);
        psel    <= 1'b1;
        pwrite  <= 1'b1;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task act(input logic [7:0] v, input int exp);
        n0 = mem.n;
        act_req    <= 1'b1;
        act_vector <= v;
        do @(posedge pclk); while (act_accept !== 1'b1);
        act_req    <= 1'b0;
        do @(posedge pclk); while (busy !== 1'b0);
        @(posedge pclk);
        chk(mem.n - n0, exp);
    endtask
    task put(input int a, input logic [31:0] d);
        {mem.m[a], mem.m[a + 1], mem.m[a + 2], mem.m[a + 3]} = d;
    endtask
    function automatic logic [31:0] wd(input int a);
        return {mem.m[a], mem.m[a + 1], mem.m[a + 2], mem.m[a + 3]};
    endfunction
    task apb_rd(input logic [31:0] a, e);
        psel    <= 1'b1;
        pwrite  <= 1'b0;
        paddr   <= a;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        chk(prdata, e);
        chk(pslverr, 32'h0);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task normal_split;
        apb_wr(32'h4, 32'h0);
        act(8'h2, 11);
        chk({mem.m[96], mem.m[97]}, 32'hABCD);
        chk({mem.m[36], mem.m[37], mem.m[38], mem.m[39]}, 32'h43);
        chk({mem.m[40], mem.m[41], mem.m[42], mem.m[43]}, 32'h62);
        chk({mem.m[44], mem.m[45], mem.m[46], mem.m[47]}, 32'h0);
        chk(irqs, 1);
        chk(cpu_irq_vector, 32'h2);
    endtask
    task read_skip;
        mem.dly = 2;
        apb_wr(32'h0, 32'h1);
        act(8'h3, 11);
        act(8'h3, 6);
        apb_wr(32'h0, 32'h0);
        apb_rd(32'h8, 32'h0000_0300);
        apb_wr(32'h0, 32'h1);
        act(8'h3, 11);
        chk(irqs, 1);
    endtask
    task chain_short;
        put(16, 32'h80);
        put(128, 32'h8800_00B1);
        put(132, 32'h8800_00C2);
        put(136, 32'h0002_0000);
        put(140, 32'h0000_00B1);
        put(144, 32'h2000_00D0);
        put(148, 32'h0005_0000);
        put(176, 32'h0011_2233);
        put(180, 32'h4455_6677);
        apb_wr(32'h0, 32'h2);
        act(8'h4, 18);
        chk(wd(194), 32'h1122_3344);
        chk(mem.m[208], 32'h11);
        chk(wd(128), 32'h8800_00B5);
        chk(wd(132), 32'h8800_00C6);
        chk(wd(136), 32'h0001_0000);
        chk(wd(148), 32'h0004_0000);
        chk(irqs, 2);
        chk(cpu_irq_vector, 32'h4);
    endtask
    task block_mode;
        put(20, 32'hE0);
        put(224, 32'hA008_0000);
        put(228, 32'hF0);
        put(232, 32'hF8);
        put(236, 32'h0202_0001);
        put(240, 32'h5A6B_0000);
        apb_wr(32'h0, 32'h0);
        act(8'h5, 12);
        chk({mem.m[248], mem.m[249]}, 32'h5A6B);
        chk(wd(228), 32'hF2);
        chk(wd(232), 32'hF8);
        chk(wd(236), 32'h0202_0000);
        chk(irqs, 3);
    endtask
    task end_of_test;
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        end_of_test;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, act_req, act_vector, paddr, pwdata} = '0;
        put(8, 32'h20);
        put(12, 32'h20);
        put(32, 32'h8408_0000);
        put(36, 32'h41);
        put(40, 32'h60);
        put(44, 32'h0001_0000);
        put(64, 32'h00AB_CD00);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        normal_split;
        read_skip;
        chain_short;
        block_mode;
        end_of_test;
    end
endmodule
